//--- verilog/sac_sequencer.sv
// conversion sequencer for a 10-bit successive-approximation converter
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "sac_defs.svh"

module sac_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_high,
    input wire logic diff_not_positive,
    output logic [4:0] input_channel_select,
    output logic [1:0] reference_select,
    output logic converter_power,
    output logic sample_hold,
    output logic [9:0] dac_code,
    output logic conversion_irq
);
    logic [7:0] channel_reg;
    logic [7:0] control_reg;
    logic [9:0] result_word;
    logic [9:0] sar_value;
    logic [9:0] trial_bit;
    logic result_locked;
    logic first_pending;
    logic extended;
    logic [6:0] prescale_count;
    logic conv_tick;
    logic diff_phase;
    logic [5:0] half_count;
    logic [4:0] cycle_count;
    logic sleep_armed;
    sac_pkg::sac_state_t state;

    logic apb_access;
    logic wr_access;
    logic rd_access;
    logic enable_bit;
    logic free_run;
    logic start_write;
    logic finish;
    logic is_differential;
    logic sleep_start;
    logic [6:0] prescale_limit;
    logic [7:0] low_byte;
    logic [7:0] high_byte;
    logic [9:0] final_code;

    // division ratio for the converter clock
    function automatic logic [6:0] sac_div_limit(input logic [2:0] sel);
        case (sel)
            3'h0: sac_div_limit = 7'h01;
            3'h1: sac_div_limit = 7'h01;
            3'h2: sac_div_limit = 7'h03;
            3'h3: sac_div_limit = 7'h07;
            3'h4: sac_div_limit = 7'h0f;
            3'h5: sac_div_limit = 7'h1f;
            3'h6: sac_div_limit = 7'h3f;
            default: sac_div_limit = 7'h7f;
        endcase
    endfunction

    // selections that pair two pins through the gain stage
    function automatic logic sac_is_diff(input logic [4:0] sel);
        sac_is_diff = (sel >= 5'h0b) && (sel <= 5'h1d);
    endfunction

    assign apb_access = psel && penable;
    assign wr_access = apb_access && pwrite;
    assign rd_access = apb_access && !pwrite;
    assign enable_bit = control_reg[`SAC_CTL_ENABLE];
    assign free_run = control_reg[`SAC_CTL_FREE_RUN];
    assign start_write = wr_access && (paddr == `SAC_OFF_CONTROL) &&
        pwdata[`SAC_CTL_ENABLE] && pwdata[`SAC_CTL_START];
    assign prescale_limit = sac_div_limit(control_reg[2:0]);
    assign is_differential = sac_is_diff(input_channel_select);
    assign finish = (state == sac_pkg::SAC_CONVERT) && conv_tick &&
        (cycle_count == (extended ? `SAC_EXTENDED_CYCLES :
                         `SAC_NORMAL_CYCLES));
    assign sleep_start = sleep_armed && enable_bit && !free_run &&
        control_reg[`SAC_CTL_DONE_IE] &&
        !control_reg[`SAC_CTL_START];
    // last trial decides the lsb; differential underflow saturates
    assign final_code = diff_not_positive && is_differential ?
        `SAC_CODE_MIN :
        (comparator_high ? sar_value : (sar_value & ~trial_bit));

    // alignment is a view, so a change shows at once
    always_comb begin
        if (channel_reg[`SAC_CH_LEFT_ALIGN]) begin
            high_byte = result_word[9:2];
            low_byte = {result_word[1:0], 6'h00};
        end else begin
            high_byte = {6'h00, result_word[9:8]};
            low_byte = result_word[7:0];
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_reg <= `SAC_CHANNEL_RESET;
        end else if (wr_access && paddr == `SAC_OFF_CHANNEL) begin
            channel_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= `SAC_CONTROL_RESET;
        end else begin
            if (wr_access && paddr == `SAC_OFF_CONTROL) begin
                control_reg[`SAC_CTL_ENABLE] <= pwdata[`SAC_CTL_ENABLE];
                control_reg[`SAC_CTL_FREE_RUN] <= pwdata[`SAC_CTL_FREE_RUN];
                control_reg[`SAC_CTL_DONE_IE] <= pwdata[`SAC_CTL_DONE_IE];
                control_reg[2:0] <= pwdata[2:0];
            end
            // start only sets; hardware clears it
            if (!enable_bit && !start_write) begin
                control_reg[`SAC_CTL_START] <= 1'b0;
            end else if (start_write || sleep_start) begin
                control_reg[`SAC_CTL_START] <= 1'b1;
            end else if (finish && !free_run) begin
                control_reg[`SAC_CTL_START] <= 1'b0;
            end
            // set wins over clear
            if (finish) begin
                control_reg[`SAC_CTL_DONE] <= 1'b1;
            end else if ((wr_access && paddr == `SAC_OFF_CONTROL &&
                          pwdata[`SAC_CTL_DONE]) ||
                         (wr_access && paddr == `SAC_OFF_SYSTEM &&
                          pwdata[`SAC_SYS_VECTOR_ACK])) begin
                control_reg[`SAC_CTL_DONE] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_armed <= 1'b0;
        end else if (wr_access && paddr == `SAC_OFF_SYSTEM) begin
            sleep_armed <= pwdata[`SAC_SYS_SLEEP];
        end else if (sleep_start) begin
            sleep_armed <= 1'b0;
        end
    end

    // ************************************************************
    // converter clock prescaler
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count <= 7'h00;
            conv_tick <= 1'b0;
            diff_phase <= 1'b0;
        end else if (!enable_bit) begin
            prescale_count <= 7'h00;
            conv_tick <= 1'b0;
            diff_phase <= 1'b0;
        end else if (prescale_count >= prescale_limit) begin
            prescale_count <= 7'h00;
            conv_tick <= 1'b1;
            diff_phase <= ~diff_phase;
        end else begin
            prescale_count <= prescale_count + 7'h01;
            conv_tick <= 1'b0;
        end
    end

    // ************************************************************
    // conversion sequence
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sac_pkg::SAC_IDLE;
            first_pending <= 1'b1;
            extended <= 1'b0;
            half_count <= 6'h00;
            cycle_count <= 5'h00;
            sar_value <= 10'h000;
            trial_bit <= 10'h000;
            sample_hold <= 1'b0;
            dac_code <= 10'h000;
            input_channel_select <= 5'h00;
            reference_select <= 2'h0;
        end else if (!enable_bit) begin
            state <= sac_pkg::SAC_IDLE;
            first_pending <= 1'b1;
            sample_hold <= 1'b0;
            half_count <= 6'h00;
            cycle_count <= 5'h00;
        end else begin
            case (state)
                sac_pkg::SAC_IDLE: begin
                    // selections latch only between conversions
                    input_channel_select <= channel_reg[4:0];
                    reference_select <= channel_reg[7:6];
                    if (control_reg[`SAC_CTL_START]) begin
                        state <= sac_pkg::SAC_WAIT_EDGE;
                    end
                end
                sac_pkg::SAC_WAIT_EDGE: begin
                    if (conv_tick && (!is_differential || diff_phase)) begin
                        state <= sac_pkg::SAC_CONVERT;
                        extended <= first_pending;
                        first_pending <= 1'b0;
                        cycle_count <= 5'h01;
                        half_count <= 6'h00;
                        sar_value <= 10'h200;
                        trial_bit <= 10'h200;
                        dac_code <= 10'h200;
                        sample_hold <= 1'b0;
                    end
                end
                sac_pkg::SAC_CONVERT: begin
                    if (conv_tick) begin
                        cycle_count <= cycle_count + 5'h01;
                        half_count <= half_count + 6'h02;
                        // hold taken one and a half cycles in, thirteen and a half when extended
                        if (half_count + 6'h01 ==
                            (extended ? `SAC_EXTENDED_SH_HALF :
                             `SAC_NORMAL_SH_HALF)) begin
                            sample_hold <= 1'b1;
                        end
                        // one bit decided per cycle once the input is held
                        if (sample_hold && trial_bit != 10'h000) begin
                            sar_value <= (comparator_high ? sar_value :
                                (sar_value & ~trial_bit)) |
                                (trial_bit >> 1);
                            dac_code <= (comparator_high ? sar_value :
                                (sar_value & ~trial_bit)) | (trial_bit >> 1);
                            trial_bit <= trial_bit >> 1;
                        end
                    end
                    if (finish) begin
                        sample_hold <= 1'b0;
                        input_channel_select <= channel_reg[4:0];
                        reference_select <= channel_reg[7:6];
                        if (free_run) begin
                            state <= sac_pkg::SAC_WAIT_EDGE;
                        end else begin
                            state <= sac_pkg::SAC_IDLE;
                        end
                    end
                end
                default: state <= sac_pkg::SAC_IDLE;
            endcase
        end
    end

    // ************************************************************
    // result store and read lock
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_word <= 10'h000;
            result_locked <= 1'b0;
        end else begin
            if (finish && !result_locked) begin
                result_word <= final_code;
            end
            if (rd_access && paddr == `SAC_OFF_RES_LOW) begin
                result_locked <= 1'b1;
            end else if (rd_access && paddr == `SAC_OFF_RES_HIGH) begin
                result_locked <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_power <= 1'b0;
            conversion_irq <= 1'b0;
        end else begin
            converter_power <= enable_bit;
            conversion_irq <= control_reg[`SAC_CTL_DONE] &&
                control_reg[`SAC_CTL_DONE_IE];
        end
    end

    // ************************************************************
    // apb slave
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `SAC_OFF_CHANNEL: prdata <= {24'h000000, channel_reg};
                    `SAC_OFF_CONTROL: prdata <= {24'h000000, control_reg};
                    `SAC_OFF_RES_LOW: prdata <= {24'h000000, low_byte};
                    `SAC_OFF_RES_HIGH: prdata <= {24'h000000, high_byte};
                    `SAC_OFF_SYSTEM: prdata <= {31'h00000000, sleep_armed};
                    `SAC_OFF_RESULT: prdata <= {22'h000000, result_word};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

//--- verilog/sac_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_OFF_CHANNEL 12'h000
`define SAC_OFF_CONTROL 12'h004
`define SAC_OFF_RES_LOW 12'h008
`define SAC_OFF_RES_HIGH 12'h00c
`define SAC_OFF_SYSTEM 12'h010
`define SAC_OFF_RESULT 12'h014
// control register fields
`define SAC_CTL_ENABLE 7
`define SAC_CTL_START 6
`define SAC_CTL_FREE_RUN 5
`define SAC_CTL_DONE 4
`define SAC_CTL_DONE_IE 3
// channel register fields
`define SAC_CH_LEFT_ALIGN 5
`define SAC_CHANNEL_RESET 8'h00
`define SAC_CONTROL_RESET 8'h00
// system register fields
`define SAC_SYS_SLEEP 0
`define SAC_SYS_VECTOR_ACK 1
// timing in converter clock cycles; hold points in half cycles
`define SAC_NORMAL_CYCLES 5'd13
`define SAC_EXTENDED_CYCLES 5'd25
`define SAC_NORMAL_SH_HALF 6'd3
`define SAC_EXTENDED_SH_HALF 6'd27
`define SAC_CODE_MIN 10'h000
`define SAC_CODE_MAX 10'h3ff
`endif

//--- verilog/sac_pkg.sv
// types for the conversion sequencer
package sac_pkg;
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_WAIT_EDGE = 2'b01,
        SAC_CONVERT = 2'b10
    } sac_state_t;
endpackage

//--- testbench/sac_sequencer_asserts.sv
// concurrent checks on the sequencer's bus and converter outputs
`timescale 1ns/1ps
module sac_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [4:0] input_channel_select,
    input wire logic converter_power,
    input wire logic sample_hold
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************
    // hold-time counter
    // ****************
    // twelve bits: the slowest divider keeps the hold up for 1408 cycles
    logic [11:0] sh_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_cnt <= 12'h000;
        end else if (sample_hold) begin
            sh_cnt <= sh_cnt + 12'h001;
        end else begin
            sh_cnt <= 12'h000;
        end
    end
    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_unmapped_err: assert property (psel && !penable |=>
        pslverr == ($past(paddr) > 12'h014 || $past(paddr[1:0]) != 2'b00))
        else $error("error response wrong for address");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_read_upper_zero: assert property (pready && !pwrite |->
        prdata[31:10] == 22'h0)
        else $error("upper read bits set");
    a_channel_held: assert property (
        sample_hold && $past(sample_hold) |->
        $stable(input_channel_select))
        else $error("channel moved during conversion");
    a_hold_length: assert property (
        $fell(sample_hold) && converter_power |-> sh_cnt >= 12'd22)
        else $error("hold phase too short");
    a_abort_drop: assert property (
        $fell(converter_power) |-> ##[0:2] !sample_hold)
        else $error("conversion not aborted");
endmodule
bind sac_sequencer sac_asserts u_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_channel_select(input_channel_select),
    .converter_power(converter_power), .sample_hold(sample_hold));

//--- testbench/test_sac_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "sac_defs.svh"
module test_sac_sequencer;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic diff_not_positive = 1'b0;
    logic [9:0] vin = 10'h000;
    logic [9:0] v;
    logic [31:0] prdata, last_rd;
    logic pready, pslverr, converter_power, sample_hold, conversion_irq;
    logic comparator_high;
    logic [4:0] input_channel_select;
    logic [1:0] reference_select;
    logic [9:0] dac_code;
    logic [32:0] q_exp[$];
    logic [32:0] q_msk[$];
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    int t0;
    // analog stand-in: gain stage saturates at ground when not positive
    assign comparator_high = diff_not_positive ? (dac_code == 10'h000)
        : (vin >= dac_code);
    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    sac_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator_high(comparator_high),
        .diff_not_positive(diff_not_positive),
        .input_channel_select(input_channel_select),
        .reference_select(reference_select),
        .converter_power(converter_power), .sample_hold(sample_hold),
        .dac_code(dac_code), .conversion_irq(conversion_irq));
    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) begin
            q_exp.push_back(e);
            q_msk.push_back(m);
        end
        @(posedge pclk);
        penable <= 1'b1;
        // request stands until ready is seen at a rising edge
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        last_rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h0, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e,
            input logic [32:0] m = 33'h1ffffffff);
        xfer(1'b0, a, 32'h0, e, m);
    endtask
    task automatic wait_done(input logic fr);
        int n;
        n = 0;
        do begin
            rd(`SAC_OFF_CONTROL, 33'h0, 33'h0);
            n++;
        end while ((fr ? !last_rd[4] : last_rd[6]) && n < 400);
        // a poll limit that runs out is a failure
        if (fr ? !last_rd[4] : last_rd[6]) begin
            miscompares++;
        end
    endtask
    task automatic conv(input logic [9:0] val, input logic [7:0] ctl);
        vin <= val;
        // the stand-in settles at once, so a fast converter clock is safe
        wr(`SAC_OFF_CONTROL, {24'h0, ctl});
        t0 = cyc;
        wait_done(1'b0);
    endtask
    // read results are compared against the oldest note
    always @(negedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite &&
                q_exp.size() > 0) begin
            chk({pslverr, prdata} & q_msk[0], q_exp[0]);
            void'(q_exp.pop_front());
            void'(q_msk.pop_front());
        end
    end
    // ****************
    // scenarios
    // ****************
    initial begin
        void'($urandom(65));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SAC_OFF_CONTROL, 33'h0);
        rd(`SAC_OFF_CHANNEL, 33'h0);
        rd(12'h018, 33'h100000000);
        wr(`SAC_OFF_CHANNEL, 32'h43);
        chk({26'h0, reference_select, input_channel_select}, 33'h0);
        conv(10'h2a5, 8'hc3);
        chk(33'(cyc - t0 >= 192 && cyc - t0 <= 230), 33'h1);
        chk({26'h0, reference_select, input_channel_select},
            33'h23);
        rd(`SAC_OFF_CONTROL, 33'h93);
        rd(`SAC_OFF_RES_LOW, 33'ha5);
        rd(`SAC_OFF_RES_HIGH, 33'h02);
        vin <= 10'h13c;
        wr(`SAC_OFF_CONTROL, 32'hc3);
        t0 = cyc;
        rd(`SAC_OFF_CONTROL, 33'h40, 33'h40);
        wr(`SAC_OFF_CHANNEL, 32'h45);
        chk({28'h0, input_channel_select}, 33'h03);
        wait_done(1'b0);
        chk(33'(cyc - t0 >= 96 && cyc - t0 <= 130), 33'h1);
        chk({28'h0, input_channel_select}, 33'h05);
        rd(`SAC_OFF_RESULT, 33'h13c);
        wr(`SAC_OFF_CONTROL, 32'h83);
        rd(`SAC_OFF_CONTROL, 33'h93);
        wr(`SAC_OFF_CONTROL, 32'h93);
        rd(`SAC_OFF_CONTROL, 33'h83);
        rd(`SAC_OFF_RES_LOW, 33'h3c);
        conv(10'h3c1, 8'hc3);
        rd(`SAC_OFF_CONTROL, 33'h93);
        rd(`SAC_OFF_RES_HIGH, 33'h01);
        conv(10'h3c1, 8'hc3);
        rd(`SAC_OFF_RES_LOW, 33'hc1);
        rd(`SAC_OFF_RES_HIGH, 33'h03);
        wr(`SAC_OFF_CHANNEL, 32'h65);
        rd(`SAC_OFF_RES_LOW, 33'h40);
        rd(`SAC_OFF_RES_HIGH, 33'hf0);
        wr(`SAC_OFF_CHANNEL, 32'h45);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom);
            conv(v, 8'hc3);
            rd(`SAC_OFF_RESULT, {23'h0, v});
        end
        wr(`SAC_OFF_CHANNEL, 32'h4b);
        diff_not_positive <= 1'b1;
        // gain stage settling after a new differential pair
        repeat (12500) @(posedge pclk);
        conv(10'h3ff, 8'hc3);
        rd(`SAC_OFF_RESULT, 33'h0);
        diff_not_positive <= 1'b0;
        wr(`SAC_OFF_CHANNEL, 32'h45);
        vin <= 10'h155;
        wr(`SAC_OFF_CONTROL, 32'hf3);
        wait_done(1'b1);
        rd(`SAC_OFF_CONTROL, 33'hf3);
        wr(`SAC_OFF_SYSTEM, 32'h2);
        rd(`SAC_OFF_CONTROL, 33'h40, 33'h50);
        wait_done(1'b1);
        rd(`SAC_OFF_RESULT, 33'h155);
        wr(`SAC_OFF_CONTROL, 32'h00);
        repeat (2) @(posedge pclk);
        chk({32'h0, converter_power}, 33'h0);
        rd(`SAC_OFF_CONTROL, 33'h0, 33'hc0);
        wr(`SAC_OFF_CONTROL, 32'h9b);
        wr(`SAC_OFF_SYSTEM, 32'h1);
        rd(`SAC_OFF_CONTROL, 33'h40, 33'h40);
        wait_done(1'b0);
        repeat (2) @(posedge pclk);
        chk({32'h0, conversion_irq}, 33'h1);
        wr(`SAC_OFF_CONTROL, 32'h9b);
        repeat (2) @(posedge pclk);
        chk({32'h0, conversion_irq}, 33'h0);
        finish_test();
    end
    // about 16000 cycles expected; 50000 leaves a wide margin
    initial begin
        #500000;
        miscompares++;
        finish_test();
    end
endmodule
